// ### hw/pte_engine.sv
`timescale 1ns/1ps
// Behaviour
// [R1] engine advances on primary loop oscillator ticks
// [R2] oscillator steered by loop or cpu word
// [R3] counting identical whichever steering source
// [R4] free-running 32-bit system time counter
// [R5] insertion counter format follows selected protocol
// [R6] both counters captured on same cycle
// [R7] arrivals stamped from system time
// [R8] departures stamped from insertion time, 1588 layout
// [R9] server: outgoing sync carries insertion stamp
// [R10] cpu writes approximate whole seconds
// [R11] fraction zeroed on next pps edge
// [R12] cpu reads back after one second
// [R13] cpu checks phase, realigns on lock loss
// [R14] client requests stamped from system time
// [R15] cpu converts arrival stamps to insertion time
// [R16] client: loop opened, cpu sets frequency
// [R17] client sync arrivals stamped in system time
// [R18] cpu may align from round trip
// [R19] frame pulse aligned to seconds transition
// [R20] boundary clock: align, then stamp forwarded packets
// [R21] physical mode: insertion counts at loop rate
// [R22] cpu may set absolute insertion value
// [R23] seconds write whole, fraction untouched until pps
module pte_engine (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] loop_word_i,
    input wire logic pps_i,
    input wire logic arrival_i,
    input wire logic depart_i,
    output logic [47:0] depart_sec_o,
    output logic [31:0] depart_frac_o,
    output logic depart_valid_o,
    output logic [31:0] dco_word_o,
    output logic frame_pulse_o
);
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [pte_pkg::CTRL_W-1:0] ctrl_ff;
    logic [31:0] cpu_word_ff;
    logic [31:0] sys_ff;
    logic [31:0] phase_ff;
    logic [31:0] sec_ff;
    logic [31:0] frac_ff;
    logic [31:0] cap_sys_ff;
    logic [31:0] cap_sec_ff;
    logic [31:0] cap_frac_ff;
    logic [31:0] arr_ff;
    logic [pte_pkg::CAP_CNT_W-1:0] cap_cnt_ff;
    logic pps_ff;
    logic pend_ff;
    logic arr_valid_ff;
    logic [47:0] dep_sec_ff;
    logic [31:0] dep_frac_ff;
    logic dep_valid_ff;
    logic frame_ff;
    logic wr_go, rd_go, wr_ctrl, wr_word, wr_sec, wr_frac, wr_stat;
    logic [32:0] nxt_phase;
    logic dco_tick, pps_rise, cap_go, frac_wrap;
    logic [1:0] proto;
    logic [31:0] step, nxt_frac_raw, steer_word;
    logic [31:0] ctrl_merge;

    // byte-lane merge for register writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // fraction rollover point for the selected protocol
    function automatic logic [32:0] frac_limit(input logic [1:0] p);
        case (p)
            pte_pkg::PROTO_PTP: frac_limit = {1'b0, pte_pkg::PTP_FRAC_MAX};
            pte_pkg::PROTO_RTP: frac_limit = {1'b0, pte_pkg::RTP_FRAC_MAX};
            default: frac_limit = 33'h100000000;
        endcase
    endfunction

    // bus decode; writes land on the edge that carries ack
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
    assign rd_go = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_ctrl = wr_go && (wb_adr_i == pte_pkg::OFF_CTRL);
    assign wr_word = wr_go && (wb_adr_i == pte_pkg::OFF_DCO_WORD);
    assign wr_sec = wr_go && (wb_adr_i == pte_pkg::OFF_INS_SEC);
    assign wr_frac = wr_go && (wb_adr_i == pte_pkg::OFF_INS_FRAC);
    assign wr_stat = wr_go && (wb_adr_i == pte_pkg::OFF_STATUS);
    assign ctrl_merge = lane_merge({27'h0, ctrl_ff}, wb_dat_i, wb_sel_i); // control bits only
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // one-cycle registered acknowledge, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
        end
    end

    // read data mux, unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= 32'h0;
        end else if (rd_go) begin
            case (wb_adr_i)
                pte_pkg::OFF_CTRL: rdat_ff <= {27'h0, ctrl_ff};
                pte_pkg::OFF_DCO_WORD: rdat_ff <= cpu_word_ff;
                pte_pkg::OFF_SYS_TIME: rdat_ff <= sys_ff;
                pte_pkg::OFF_INS_SEC: rdat_ff <= sec_ff;
                pte_pkg::OFF_INS_FRAC: rdat_ff <= frac_ff;
                pte_pkg::OFF_CAP_SYS: rdat_ff <= cap_sys_ff;
                pte_pkg::OFF_CAP_SEC: rdat_ff <= cap_sec_ff;
                pte_pkg::OFF_CAP_FRAC: rdat_ff <= cap_frac_ff;
                pte_pkg::OFF_ARR_STAMP: rdat_ff <= arr_ff;
                pte_pkg::OFF_STATUS: rdat_ff <= {29'h0, ctrl_ff[pte_pkg::CTRL_CPU_STEER],
                                                 arr_valid_ff, pend_ff};
                default: rdat_ff <= 32'h0;
            endcase
        end
    end

    // control and cpu steering word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= pte_pkg::CTRL_RST;
            cpu_word_ff <= pte_pkg::DCO_WORD_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= ctrl_merge[pte_pkg::CTRL_W-1:0];
            end
            if (wr_word) begin
                cpu_word_ff <= lane_merge(cpu_word_ff, wb_dat_i, wb_sel_i);
            end
        end
    end

    // steering source select: loop filter or cpu word
    assign steer_word = ctrl_ff[pte_pkg::CTRL_CPU_STEER] ? cpu_word_ff : loop_word_i; // R2 R16 R21
    assign dco_word_o = steer_word;

    // oscillator phase accumulator; its carry is the engine's tick
    assign nxt_phase = {1'b0, phase_ff} + {1'b0, steer_word};
    assign dco_tick = nxt_phase[32]; // R1 R3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= 32'h0;
        end else begin
            phase_ff <= nxt_phase[31:0];
        end
    end

    // free-running system time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_ff <= 32'h0;
        end else begin
            sys_ff <= sys_ff + 32'h1; // R4
        end
    end

    // protocol-dependent step and fraction wrap
    assign proto = ctrl_ff[pte_pkg::CTRL_PROTO_LO +: 2];
    always_comb begin
        case (proto)
            pte_pkg::PROTO_PTP: step = pte_pkg::PTP_STEP;
            pte_pkg::PROTO_NTP: step = pte_pkg::NTP_STEP;
            default: step = pte_pkg::RTP_STEP;
        endcase
    end
    assign frac_wrap = ({1'b0, frac_ff} + {1'b0, step}) >= frac_limit(proto); // R5
    assign nxt_frac_raw = frac_wrap ? (32'(({1'b0, frac_ff} + {1'b0, step})
                                            - frac_limit(proto))) : frac_ff + step;

    // pps edge detect
    assign pps_rise = pps_i && !pps_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pps_ff <= 1'b0;
        end else begin
            pps_ff <= pps_i;
        end
    end

    // insertion counter: seconds and fraction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_ff <= 32'h0;
            frac_ff <= 32'h0;
        end else begin
            if (wr_sec) begin
                sec_ff <= lane_merge(sec_ff, wb_dat_i, wb_sel_i); // R10 R23 R22
            end else if (dco_tick && frac_wrap) begin
                sec_ff <= sec_ff + 32'h1;
            end
            if (pps_rise && pend_ff) begin
                frac_ff <= 32'h0; // R11
            end else if (wr_frac) begin
                frac_ff <= lane_merge(frac_ff, wb_dat_i, wb_sel_i); // R22 R18
            end else if (dco_tick) begin
                frac_ff <= nxt_frac_raw; // R3 R21
            end
        end
    end

    // alignment pending: set by seconds write, cleared at pps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_ff <= 1'b0;
        end else if (wr_sec) begin
            pend_ff <= 1'b1; // R11
        end else if (pps_rise) begin
            pend_ff <= 1'b0;
        end
    end

    // periodic or cpu-requested capture of the counter pair
    assign cap_go = (cap_cnt_ff == pte_pkg::CAP_CNT_W'(pte_pkg::CAP_CYCLES - 1))
                    || ctrl_ff[pte_pkg::CTRL_CAP_NOW];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_cnt_ff <= '0;
            cap_sys_ff <= 32'h0;
            cap_sec_ff <= 32'h0;
            cap_frac_ff <= 32'h0;
        end else begin
            cap_cnt_ff <= cap_go ? '0 : cap_cnt_ff + 1'b1;
            if (cap_go) begin
                cap_sys_ff <= sys_ff; // R6
                cap_sec_ff <= sec_ff;
                cap_frac_ff <= frac_ff;
            end
        end
    end

    // arrival stamp in system time; new arrival beats a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arr_ff <= 32'h0;
            arr_valid_ff <= 1'b0;
        end else begin
            if (arrival_i) begin
                arr_ff <= sys_ff; // R7 R14 R17
            end
            if (arrival_i) begin
                arr_valid_ff <= 1'b1;
            end else if (wr_stat && wb_sel_i[0] && wb_dat_i[pte_pkg::ST_ARR_VALID]) begin
                arr_valid_ff <= 1'b0;
            end
        end
    end

    // departure stamp from insertion time, 48-bit seconds and 32-bit fraction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dep_sec_ff <= 48'h0;
            dep_frac_ff <= 32'h0;
            dep_valid_ff <= 1'b0;
        end else begin
            dep_valid_ff <= depart_i;
            if (depart_i) begin
                dep_sec_ff <= {16'h0, sec_ff}; // R8 R9 R20
                dep_frac_ff <= frac_ff;
            end
        end
    end
    assign depart_sec_o = dep_sec_ff;
    assign depart_frac_o = dep_frac_ff;
    assign depart_valid_o = dep_valid_ff;

    // frame pulse on the seconds transition of the insertion counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_ff <= 1'b0;
        end else begin
            frame_ff <= ctrl_ff[pte_pkg::CTRL_FRAME_EN] && dco_tick && frac_wrap
                        && !wr_sec; // R19
        end
    end
    assign frame_pulse_o = frame_ff;

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_sys_free: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        1'b1 |=> sys_ff == $past(sys_ff) + 32'h1) else $error("system time skipped");
    a_pps_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        pps_rise && pend_ff && !wr_sec |=> frac_ff == 32'h0 && !pend_ff)
        else $error("fraction not zeroed");
    a_sec_write: assert property (@(posedge clk_i) disable iff (rst_i) // R23
        wr_sec && wb_sel_i == 4'hf |=> sec_ff == $past(wb_dat_i) && pend_ff)
        else $error("seconds write lost");
    a_arr_stamp: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        arrival_i |=> arr_ff == $past(sys_ff) && arr_valid_ff) else $error("arrival stamp wrong");
    a_cap_pair: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        cap_go |=> cap_sys_ff == $past(sys_ff) && cap_frac_ff == $past(frac_ff))
        else $error("capture pair mismatch");
    a_dep_stamp: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        depart_i |=> depart_valid_o && depart_frac_o == $past(frac_ff))
        else $error("departure stamp wrong");
    a_steer_src: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        !ctrl_ff[pte_pkg::CTRL_CPU_STEER] |-> dco_word_o == loop_word_i)
        else $error("wrong steering source");
    a_frac_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        !dco_tick && !wr_frac && !(pps_rise && pend_ff) |=> $stable(frac_ff))
        else $error("fraction moved without tick");
endmodule // pte_engine

// ### hw/pte_pkg.sv
package pte_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DCO_WORD = 8'h04;
    localparam logic [7:0] OFF_SYS_TIME = 8'h08;
    localparam logic [7:0] OFF_INS_SEC = 8'h0c;
    localparam logic [7:0] OFF_INS_FRAC = 8'h10;
    localparam logic [7:0] OFF_CAP_SYS = 8'h14;
    localparam logic [7:0] OFF_CAP_SEC = 8'h18;
    localparam logic [7:0] OFF_CAP_FRAC = 8'h1c;
    localparam logic [7:0] OFF_ARR_STAMP = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    // control field positions
    localparam int CTRL_CPU_STEER = 0;
    localparam int CTRL_PROTO_LO = 1;
    localparam int CTRL_FRAME_EN = 3;
    localparam int CTRL_CAP_NOW = 4;
    localparam int CTRL_W = 5;
    // status field positions
    localparam int ST_ALIGN_PEND = 0;
    localparam int ST_ARR_VALID = 1;
    localparam int ST_CPU_STEER = 2;
    // timing protocol codes
    localparam logic [1:0] PROTO_PTP = 2'h0;
    localparam logic [1:0] PROTO_NTP = 2'h1;
    localparam logic [1:0] PROTO_RTP = 2'h2;
    // fraction rollover for PTP and RTP, step per oscillator tick for each protocol
    localparam logic [31:0] PTP_FRAC_MAX = 32'h3b9aca00;
    localparam logic [31:0] RTP_FRAC_MAX = 32'h07735940;
    localparam logic [31:0] PTP_STEP = 32'h00000008;
    localparam logic [31:0] NTP_STEP = 32'h00000022;
    localparam logic [31:0] RTP_STEP = 32'h00000001;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [31:0] DCO_WORD_RST = 32'h80000000;
    // timing: clock period and periodic capture of the counter pair
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CAP_PERIOD_NS = 8000;
    localparam int CAP_CYCLES = (CAP_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int CAP_CNT_W = 10;
endpackage

// ### verif/pte_cpu_model.sv
`timescale 1ns/1ps
// host cpu model: one classic bus cycle per request pulse
module pte_cpu_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic done_o,
    output logic [31:0] rdat_o,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [3:0] wb_sel_o,
    output logic [7:0] wb_adr_o,
    output logic [31:0] wb_dat_o,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i
);
    // idle bus at time zero
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_sel_o = 4'h0;
        wb_adr_o = 8'h00;
        wb_dat_o = 32'h0;
        done_o = 1'b0;
        rdat_o = 32'h0;
    end

    // request held until the ack edge, then released for a cycle
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (wb_cyc_o && wb_ack_i) begin
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
            wb_sel_o <= 4'h0;
            wb_adr_o <= ~wb_adr_o; // released lines lose their value
            wb_dat_o <= ~wb_dat_o;
            rdat_o <= wb_dat_i;
            done_o <= 1'b1;
        end else if (!wb_cyc_o && req_i) begin
            wb_cyc_o <= 1'b1;
            wb_stb_o <= 1'b1;
            wb_we_o <= we_i;
            wb_sel_o <= 4'hf;
            wb_adr_o <= adr_i;
            wb_dat_o <= dat_i;
        end
    end
endmodule // pte_cpu_model

// ### verif/testbench.sv
`timescale 1ns/1ps
// self-checking bench for the timestamp engine
module testbench;
    logic clk, rst, req, we, done, pps, arr, dep, cyc, stb, bwe, ack, dvalid, frame;
    logic [3:0] sel;
    logic [7:0] adr, badr;
    logic [31:0] wdat, rdat, loop_word, rd, bdat, dato, dco, dfrac;
    logic [47:0] dsec;
    int errors, cmp_count;
    int tick_n = 0;

    pte_cpu_model i_pte_cpu_model (.clk_i(clk), .req_i(req), .we_i(we), .adr_i(adr),
        .dat_i(wdat), .done_o(done), .rdat_o(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(bwe), .wb_sel_o(sel), .wb_adr_o(badr), .wb_dat_o(bdat),
        .wb_ack_i(ack), .wb_dat_i(dato));
    pte_engine i_pte_engine (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(bwe), .wb_adr_i(badr), .wb_sel_i(sel), .wb_dat_i(bdat), .wb_dat_o(dato),
        .wb_ack_o(ack), .loop_word_i(loop_word), .pps_i(pps), .arrival_i(arr),
        .depart_i(dep), .depart_sec_o(dsec), .depart_frac_o(dfrac),
        .depart_valid_o(dvalid), .dco_word_o(dco), .frame_pulse_o(frame));

    // clock and cycle count
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) tick_n <= tick_n + 1;

    // compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one bus cycle through the cpu model, read data left in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        we <= w;
        adr <= a;
        wdat <= d;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        while (done !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) errors++;
        rd = rdat;
    endtask

    // one-cycle strobe on arrival or departure
    task automatic strobe(input logic is_dep);
        if (is_dep) dep <= 1'b1;
        else arr <= 1'b1;
        @(posedge clk);
        dep <= 1'b0;
        arr <= 1'b0;
        @(posedge clk);
    endtask

    // pps held high a few cycles
    task automatic pulse_pps();
        pps <= 1'b1;
        repeat (3) @(posedge clk);
        pps <= 1'b0;
        @(posedge clk);
    endtask

    // reset values and unmapped read
    task automatic t_reset();
        bus(1'b0, pte_pkg::OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        bus(1'b0, pte_pkg::OFF_DCO_WORD, 32'h0);
        chk("dco_word", 32'h80000000, rd);
        bus(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("dco_out", loop_word, dco);
        $display("test reset done");
    endtask

    // steering source follows the cpu steer bit
    task automatic t_steer();
        bus(1'b1, pte_pkg::OFF_DCO_WORD, 32'h12345678);
        chk("dco_loop", loop_word, dco);
        bus(1'b1, pte_pkg::OFF_CTRL, 32'h1);
        chk("dco_cpu", 32'h12345678, dco);
        bus(1'b0, pte_pkg::OFF_STATUS, 32'h0);
        chk("status", 32'h4, rd);
        bus(1'b1, pte_pkg::OFF_DCO_WORD, 32'h80000000);
        $display("test steer done");
    endtask

    // arrival stamps count system cycles whatever the steering does
    task automatic t_arrival();
        int c0, t0;
        logic [31:0] a0, s0;
        bus(1'b1, pte_pkg::OFF_CTRL, 32'h0);
        c0 = tick_n;
        strobe(1'b0);
        bus(1'b0, pte_pkg::OFF_ARR_STAMP, 32'h0);
        a0 = rd;
        loop_word <= 32'hffffffff;
        t0 = tick_n;
        bus(1'b0, pte_pkg::OFF_SYS_TIME, 32'h0);
        s0 = rd;
        t0 = tick_n - t0;
        bus(1'b0, pte_pkg::OFF_SYS_TIME, 32'h0);
        chk("sys_gap", t0, rd - s0);
        repeat (20) @(posedge clk);
        c0 = tick_n - c0;
        strobe(1'b0);
        bus(1'b0, pte_pkg::OFF_ARR_STAMP, 32'h0);
        chk("arr_diff", c0, rd - a0);
        loop_word <= 32'h80000000;
        bus(1'b0, pte_pkg::OFF_STATUS, 32'h0);
        chk("arr_valid", 32'h1, {31'h0, rd[1]});
        bus(1'b1, pte_pkg::OFF_STATUS, 32'h2);
        bus(1'b0, pte_pkg::OFF_STATUS, 32'h0);
        chk("arr_clear", 32'h0, {31'h0, rd[1]});
        $display("test arrival done");
    endtask

    // two departures 100 cycles apart: 50 oscillator ticks of one step
    task automatic t_depart(input logic [31:0] ctrl, input logic [31:0] step);
        logic [31:0] f0;
        int c0;
        bus(1'b1, pte_pkg::OFF_CTRL, ctrl);
        c0 = tick_n;
        strobe(1'b1);
        chk("dep_valid", 32'h1, {31'h0, dvalid});
        f0 = dfrac;
        while (tick_n - c0 < 100) @(posedge clk);
        strobe(1'b1);
        chk("dep_frac", 32'd50 * step, dfrac - f0);
        $display("test depart done");
    endtask

    // seconds write, then fraction zeroed on the pps edge
    task automatic t_align();
        logic [31:0] f0;
        bus(1'b0, pte_pkg::OFF_INS_FRAC, 32'h0);
        f0 = rd;
        pulse_pps();
        bus(1'b0, pte_pkg::OFF_INS_FRAC, 32'h0);
        chk("frac_runs", 32'h1, {31'h0, rd > f0});
        bus(1'b1, pte_pkg::OFF_INS_SEC, 32'h5);
        bus(1'b0, pte_pkg::OFF_STATUS, 32'h0);
        chk("pending", 32'h1, {31'h0, rd[0]});
        bus(1'b0, pte_pkg::OFF_INS_SEC, 32'h0);
        chk("sec", 32'h5, rd);
        pulse_pps();
        bus(1'b0, pte_pkg::OFF_INS_FRAC, 32'h0);
        chk("frac_zero", 32'h1, {31'h0, rd < 32'h400});
        bus(1'b0, pte_pkg::OFF_STATUS, 32'h0);
        chk("pend_clr", 32'h0, {31'h0, rd[0]});
        bus(1'b0, pte_pkg::OFF_INS_SEC, 32'h0);
        chk("sec_kept", 32'h5, rd);
        $display("test align done");
    endtask

    // absolute fraction set and frame pulse on the seconds carry
    task automatic t_frame();
        int n;
        n = 0;
        bus(1'b1, pte_pkg::OFF_CTRL, 32'h9);
        bus(1'b1, pte_pkg::OFF_INS_FRAC, 32'd1000);
        bus(1'b0, pte_pkg::OFF_INS_FRAC, 32'h0);
        chk("frac_set", 32'h1, {31'h0, rd >= 1000 && rd < 1256});
        bus(1'b1, pte_pkg::OFF_INS_FRAC, pte_pkg::PTP_FRAC_MAX - 32'h40);
        while (frame !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("frame", 32'h1, {31'h0, n < 200});
        bus(1'b0, pte_pkg::OFF_INS_SEC, 32'h0);
        chk("sec_carry", 32'h6, rd);
        $display("test frame done");
    endtask

    // pair capture every cycle, periodic capture, arrival converted to insertion time
    task automatic t_capture();
        logic [31:0] s1, a1, f1, cs;
        int t1;
        bus(1'b1, pte_pkg::OFF_CTRL, 32'h10);
        t1 = tick_n;
        bus(1'b0, pte_pkg::OFF_SYS_TIME, 32'h0);
        s1 = rd;
        t1 = tick_n - t1;
        bus(1'b0, pte_pkg::OFF_CAP_SYS, 32'h0);
        chk("cap_each", t1 - 1, rd - s1);
        arr <= 1'b1;
        dep <= 1'b1;
        @(posedge clk);
        arr <= 1'b0;
        dep <= 1'b0;
        bus(1'b1, pte_pkg::OFF_CTRL, 32'h0);
        f1 = dfrac;
        chk("dep_sec", 32'h6, dsec[31:0]);
        chk("dep_sec_hi", 32'h0, {16'h0, dsec[47:32]});
        bus(1'b0, pte_pkg::OFF_ARR_STAMP, 32'h0);
        a1 = rd;
        bus(1'b0, pte_pkg::OFF_CAP_SYS, 32'h0);
        cs = rd;
        bus(1'b0, pte_pkg::OFF_CAP_SEC, 32'h0);
        chk("cap_sec", 32'h6, rd);
        bus(1'b0, pte_pkg::OFF_CAP_FRAC, 32'h0);
        chk("convert", 32'h1, {31'h0, rd - f1 - 32'd4 * (cs - a1) + 32'd4 <= 32'd8});
        repeat (1100) @(posedge clk);
        bus(1'b0, pte_pkg::OFF_CAP_SYS, 32'h0);
        chk("cap_period", pte_pkg::CAP_CYCLES, rd - cs);
        $display("test capture done");
    endtask

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        req = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        pps = 1'b0;
        arr = 1'b0;
        dep = 1'b0;
        loop_word = 32'h80000000;
        errors = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_steer();
        t_arrival();
        t_depart(32'h1, pte_pkg::PTP_STEP);
        t_depart(32'h0, pte_pkg::PTP_STEP);
        t_depart(32'h3, pte_pkg::NTP_STEP);
        t_depart(32'h5, pte_pkg::RTP_STEP);
        t_align();
        t_frame();
        t_capture();
        results();
    end
endmodule // testbench
